// File: rtl/ppab_regs.vh
`ifndef PPAB_REGS_VH
`define PPAB_REGS_VH
// register indices as printed; byte address is four times the index
`define PPAB_IDX_A_DATA 8'h00
`define PPAB_IDX_A_DIR 8'h01
`define PPAB_IDX_B_DIR 8'h02
`define PPAB_IDX_B_DATA 8'h04
`define PPAB_IDX_B_ALT 8'h10
`define PPAB_IDX_STATUS 8'h11
// second port alternate control fields
`define PPAB_ALT_PULLUP_POS 0
`define PPAB_ALT_SEG_POS 1
// status fields
`define PPAB_STAT_EXP_POS 0
`define PPAB_STAT_SEG_POS 1
// reset values
`define PPAB_DIR_RST 8'h00
`define PPAB_ALT_RST 8'h00
`define PPAB_DATA_PWRUP 8'h00
`endif

// File: rtl/ppab_ports.v
`include "ppab_regs.vh"
`default_nettype none

module ppab_ports (
    input wire clock,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire expanded_mode,
    input wire [7:0] first_port_pin_in,
    output wire [7:0] first_port_pin_out,
    output wire [7:0] first_port_pin_oe,
    input wire [7:0] timer_own,
    input wire [7:0] timer_out,
    input wire [7:0] timer_drive,
    output wire [7:0] timer_in,
    input wire [7:0] upper_address,
    input wire [3:0] segment_data,
    input wire [7:0] second_port_pin_in,
    output wire [7:0] second_port_pin_out,
    output wire [7:0] second_port_pin_oe,
    output wire [7:0] second_port_pullup_en
);

////////////////////////////////////////////////////////////////////////////////
// bus phase tracking

localparam ST_IDLE = 1'b0;
localparam ST_ACCESS = 1'b1;

reg state_q;
reg state_d;
wire setup;
wire access;

assign setup = psel & ~penable;
assign access = psel & penable;

// every setup is answered in the very next cycle, no wait states
always @* begin
    state_d = ST_IDLE;
    case (state_q)
        ST_IDLE: begin
            if (setup) begin
                state_d = ST_ACCESS;
            end
        end
        ST_ACCESS: begin
            if (setup) begin
                state_d = ST_ACCESS;
            end
        end
        default: begin
            state_d = ST_IDLE;
        end
    endcase
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        state_q <= ST_IDLE;
    end else begin
        state_q <= state_d;
    end
end

assign pready = (state_q == ST_ACCESS);

////////////////////////////////////////////////////////////////////////////////
// address decode

wire [9:0] idx;
wire aligned;
wire b_mapped;
wire idx_ok;
reg hit_a_data;
reg hit_a_dir;
reg hit_b_data;
reg hit_b_dir;
reg hit_b_alt;
reg hit_status;

assign idx = paddr[11:2];
assign aligned = (paddr[1:0] == 2'h0);
// second port data and direction registers vanish from the map in expanded/test mode; alternate control stays
assign b_mapped = ~expanded_mode;

always @* begin
    hit_a_data = 1'b0;
    hit_a_dir = 1'b0;
    hit_b_data = 1'b0;
    hit_b_dir = 1'b0;
    hit_b_alt = 1'b0;
    hit_status = 1'b0;
    if (aligned) begin
        case (idx)
            {2'h0, `PPAB_IDX_A_DATA}: begin
                hit_a_data = 1'b1;
            end
            {2'h0, `PPAB_IDX_A_DIR}: begin
                hit_a_dir = 1'b1;
            end
            {2'h0, `PPAB_IDX_B_DATA}: begin
                hit_b_data = b_mapped;
            end
            {2'h0, `PPAB_IDX_B_DIR}: begin
                hit_b_dir = b_mapped;
            end
            {2'h0, `PPAB_IDX_B_ALT}: begin
                hit_b_alt = 1'b1;
            end
            {2'h0, `PPAB_IDX_STATUS}: begin
                hit_status = 1'b1;
            end
            default: begin
                hit_status = 1'b0;
            end
        endcase
    end
end

assign idx_ok = hit_a_data | hit_a_dir | hit_b_data | hit_b_dir | hit_b_alt | hit_status;

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] a_data_q;
reg [7:0] a_dir_q;
reg [7:0] b_data_q;
reg [7:0] b_dir_q;
reg [7:0] b_alt_q;
reg wr_a_data;
reg wr_a_dir;
reg wr_b_data;
reg wr_b_dir;
reg wr_b_alt;
wire wr_en;
wire seg_on;
wire pullup_sel;

// only the low byte is carried; upper write bits are ignored
function [7:0] low_byte;
    input [31:0] word;
    begin
        low_byte = word[7:0];
    end
endfunction

assign wr_en = access & pwrite & pready;
assign seg_on = b_alt_q[`PPAB_ALT_SEG_POS];
assign pullup_sel = b_alt_q[`PPAB_ALT_PULLUP_POS];

always @* begin
    wr_a_data = 1'b0;
    wr_a_dir = 1'b0;
    wr_b_data = 1'b0;
    wr_b_dir = 1'b0;
    wr_b_alt = 1'b0;
    if (wr_en) begin
        wr_a_data = hit_a_data;
        wr_a_dir = hit_a_dir;
        wr_b_data = hit_b_data;
        wr_b_dir = hit_b_dir;
        wr_b_alt = hit_b_alt;
    end
end

// data latches have no reset: contents kept across reset
always @(posedge clock) begin
    if (wr_a_data) begin
        a_data_q <= low_byte(pwdata);
    end
    if (wr_b_data) begin
        b_data_q <= low_byte(pwdata);
    end
end

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        a_dir_q <= `PPAB_DIR_RST;
        b_dir_q <= `PPAB_DIR_RST;
        b_alt_q <= `PPAB_ALT_RST;
    end else begin
        if (wr_a_dir) begin
            a_dir_q <= low_byte(pwdata);
        end
        if (wr_b_dir) begin
            b_dir_q <= low_byte(pwdata);
        end
        if (wr_b_alt) begin
            b_alt_q <= {6'h00, pwdata[1:0]};
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path

reg [7:0] rd_byte;
reg [31:0] rdata_q;
reg err_q;

// read value mixes pin level and latch per direction bit
function [7:0] port_view;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pins;
    begin
        port_view = (dir & latch) | (~dir & pins);
    end
endfunction

function [7:0] status_word;
    input exp;
    input seg;
    begin
        status_word = {6'h00, seg, exp};
    end
endfunction

always @* begin
    rd_byte = 8'h00;
    if (hit_a_data) begin
        rd_byte = port_view(a_dir_q, a_data_q, first_port_pin_in);
    end else if (hit_a_dir) begin
        rd_byte = a_dir_q;
    end else if (hit_b_data) begin
        rd_byte = port_view(b_dir_q, b_data_q, second_port_pin_in);
    end else if (hit_b_dir) begin
        rd_byte = b_dir_q;
    end else if (hit_b_alt) begin
        rd_byte = b_alt_q;
    end else if (hit_status) begin
        rd_byte = status_word(expanded_mode, seg_on);
    end
end

// read data registered at setup; refused requests answer zero
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        rdata_q <= 32'h0000_0000;
        err_q <= 1'b0;
    end else if (setup) begin
        err_q <= ~idx_ok;
        if (!pwrite && idx_ok) begin
            rdata_q <= {24'h00_0000, rd_byte};
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
end

assign prdata = rdata_q;
assign pslverr = access & pready & err_q;

////////////////////////////////////////////////////////////////////////////////
// first port pins

reg [7:0] a_out_c;
reg [7:0] a_oe_c;
integer ai;

// one pin: the alternate function wins over the port latch when it owns the pin
function [1:0] pin_pick;
    input own;
    input alt_val;
    input alt_oe;
    input latch;
    input dir;
    begin
        if (own) begin
            pin_pick = {alt_oe, alt_val};
        end else begin
            pin_pick = {dir, latch};
        end
    end
endfunction

// timer-owned bits take timer drive; latch kept but ignored
always @* begin
    a_out_c = 8'h00;
    a_oe_c = 8'h00;
    for (ai = 0; ai < 8; ai = ai + 1) begin
        {a_oe_c[ai], a_out_c[ai]} = pin_pick(timer_own[ai], timer_out[ai],
            timer_drive[ai], a_data_q[ai], a_dir_q[ai]);
    end
end

assign first_port_pin_out = a_out_c;
assign first_port_pin_oe = a_oe_c;
assign timer_in = first_port_pin_in;

////////////////////////////////////////////////////////////////////////////////
// second port pins

reg [7:0] b_out_c;
reg [7:0] b_oe_c;
reg [7:0] b_pu_c;
integer bi;
integer pi;

// segment drivers win in every mode, then address, then plain port
always @* begin
    b_out_c = 8'h00;
    b_oe_c = 8'h00;
    for (bi = 0; bi < 8; bi = bi + 1) begin
        {b_oe_c[bi], b_out_c[bi]} = pin_pick(expanded_mode, upper_address[bi],
            1'b1, b_data_q[bi], b_dir_q[bi]);
        if (seg_on && (bi >= 4)) begin
            {b_oe_c[bi], b_out_c[bi]} = {1'b1, segment_data[bi[1:0]]};
        end
    end
end

// pull-ups only on undriven pins outside expanded mode
always @* begin
    b_pu_c = 8'h00;
    for (pi = 0; pi < 8; pi = pi + 1) begin
        if (pullup_sel && !expanded_mode && !b_oe_c[pi]) begin
            b_pu_c[pi] = 1'b1;
        end
    end
end

assign second_port_pin_out = b_out_c;
assign second_port_pin_oe = b_oe_c;
assign second_port_pullup_en = b_pu_c;

endmodule // ppab_ports
`default_nettype wire

// File: verif/ppab_checker.sv
`default_nettype none
module ppab_checker (
    input wire clock,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire expanded_mode,
    input wire [7:0] upper_address,
    input wire [7:0] second_port_pin_out,
    input wire [7:0] second_port_pullup_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    answer_one_a: assert property (psel && !penable |=> pready) else $error("late");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray err");
    unmapped_err_a:
        assert property (psel && !penable && paddr == 12'h00c |=> pslverr)
        else $error("unmapped");
    addr_out_a:
        assert property (expanded_mode |-> second_port_pin_out[3:0] == upper_address[3:0])
        else $error("address");
    map_gone_a:
        assert property (expanded_mode && psel && !penable && paddr == 12'h010
        |=> pslverr && prdata == 32'h0) else $error("mapped");
    no_pullup_a:
        assert property (expanded_mode |-> second_port_pullup_en == 8'h00)
        else $error("pullup");
    reset_pullup_a: assert property ($rose(rstn) |-> !second_port_pullup_en) else $error("rst");
    cover property (psel && penable && pslverr);
    cover property (expanded_mode && pready);
    cover property (second_port_pullup_en == 8'h0f);
endmodule // ppab_checker
bind ppab_ports ppab_checker i_chk (.*);
`default_nettype wire

// File: verif/ppab_pins.sv
`default_nettype none
module ppab_pins (
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe,
    output logic [7:0] a_in,
    input wire logic [7:0] b_out,
    input wire logic [7:0] b_oe,
    input wire logic [7:0] b_pu,
    output logic [7:0] b_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // released pins show the outside level, pulled ones go high
    assign a_in = (a_oe & a_out) | (~a_oe & 8'h3c);
    assign b_in = (b_oe & b_out) | (~b_oe & (b_pu | 8'h3c));
endmodule // ppab_pins
`default_nettype wire

// File: verif/ppab_ports_tb.sv
`default_nettype none
module ppab_ports_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = '0, rstn = '0, psel = '0, penable = '0, pwrite = '0, expanded_mode = '0, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr;
    logic [7:0] timer_own = '0, timer_out = '0, timer_drive = 8'h03, upper_address = 8'h9e;
    logic [7:0] timer_in, a_in, a_out, a_oe, b_in, b_out, b_oe, b_pu;
    logic [3:0] segment_data = 4'h9;
    int mismatches = 0, n_tests = 0;
    always #25 clock = ~clock;
    ppab_ports i_dut (.*, .first_port_pin_in(a_in), .first_port_pin_out(a_out),
        .first_port_pin_oe(a_oe), .second_port_pin_in(b_in), .second_port_pin_out(b_out),
        .second_port_pin_oe(b_oe), .second_port_pullup_en(b_pu));
    ppab_pins i_pins (.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) mismatches++;
        if (g !== e) $display("unexpected at %0t got %h exp %h", $time, g, e);
    endtask
    task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic complete_run;
        $display("n_tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000 mismatches++;
        complete_run;
    end
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        xf(0, 12'h004, 0);
        chk({rd[7:0], a_oe}, 32'h0);
        xf(1, 12'h000, 32'h5a);
        xf(1, 12'h004, 32'h0f);
        xf(0, 12'h000, 0);
        chk(rd, 32'h3a);
        timer_own <= 8'h03;
        timer_out <= 8'h02;
        xf(1, 12'h000, 32'hff);
        @(negedge clock);
        chk(a_out[3:0], 4'he);
        chk(timer_in, 32'h3e);
        xf(0, 12'h000, 0);
        chk(rd, 32'h3f);
        xf(1, 12'h040, 32'h03);
        xf(0, 12'h010, 0);
        chk(rd, 32'h9f);
        chk(b_pu, 8'h0f);
        xf(1, 12'h008, 32'h0f);
        xf(1, 12'h010, 32'ha5);
        xf(0, 12'h008, 0);
        chk(rd, 32'h0f);
        xf(0, 12'h010, 0);
        chk(rd, 32'h95);
        expanded_mode <= 1'b1;
        xf(0, 12'h010, 0);
        chk({er, rd[7:0], b_out[3:0]}, 32'h100e);
        chk(b_oe, 8'hff);
        xf(1, 12'h010, 32'h00);
        xf(0, 12'h044, 0);
        chk(rd, 32'h03);
        xf(0, 12'h00c, 0);
        chk(er, 1'b1);
        expanded_mode <= 1'b0;
        xf(0, 12'h010, 0);
        chk(rd, 32'h95);
        complete_run;
    end
endmodule // ppab_ports_tb
`default_nettype wire
